// ---- core/psc_params.svh ----
// constants of the pipelined sync sram cycle control
`ifndef PSC_PARAMS_SVH
`define PSC_PARAMS_SVH
`define PSC_ADDR_W 20
`define PSC_LANES 4
`define PSC_LANE_W 9
`define PSC_DATA_W 36
`define PSC_CNT_W 2
`define PSC_CNT_ZERO 2'h0
`define PSC_CNT_ONE 2'h1
`define PSC_LANES_NONE 4'h0
`define PSC_LANES_ALL 4'hF
`define PSC_ORDER_LINEAR 1'h0
`define PSC_ORDER_INTERLEAVE 1'h1
`endif

// ---- core/psc_pkg.sv ----
// types of the pipelined sync sram cycle control
`default_nettype none
package psc_pkg;
  // one-hot cycle state of the access logic
  typedef enum logic [3:0] {
    PSC_ST_IDLE  = 4'h1,
    PSC_ST_READ  = 4'h2,
    PSC_ST_WRITE = 4'h4,
    PSC_ST_SLEEP = 4'h8
  } psc_state_t;
endpackage : psc_pkg
`default_nettype wire

// ---- core/psc_core.sv ----
// cycle decode, burst counter and data pin control of the sram
`include "psc_params.svh"
`default_nettype none
// Function
// (R1) strap high steps low address bits in interleaved order
// (R2) strap low steps low address bits in linear wrap order
// (R3) bad chip enables with a taken strobe give a deselect, pins float
// (R4) sleep high ignores all controls and floats the data pins
// (R5) processor strobe with all enables starts a read burst
// (R6) writes only after a processor strobe cycle or on controller strobe
// (R7) controller strobe alone starts a burst, write if write low
// (R8) no strobe, advance low: step counter, read or write
// (R9) no strobe, advance high: hold address, read or write again
// (R10) write low on global write or gate plus any lane select
// (R11) controller drives lane selects low to pick lanes
// (R12) write stores only selected 9-bit lanes, global write all
// (R13) output enable acts asynchronously and is masked in writes
// (R14) read drives pins when output enable low, else floats
// (R15) controller raises output enable before a write
// (R16) two-bit counter loaded from low address bits, wraps after four; here cleared at burst start and added to or xored with those bits
// (R17) processor strobe write takes two clocks, data on the second
// (R18) read data leave the output register one clock later
// (R19) pins stay floating in the first cycle out of deselect
// (R20) counter and state are meaningless until a strobe loads them
module psc_core (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // address and strobes
  input wire logic [`PSC_ADDR_W-1:0] ADDR,
  input wire logic PROC_ADDR_STROBE_N,
  input wire logic CTRL_ADDR_STROBE_N,
  input wire logic BURST_STEP_N,
  // chip selects
  input wire logic CHIP_SEL_PRIMARY_N,
  input wire logic CHIP_SEL_SECOND,
  input wire logic CHIP_SEL_THIRD_N,
  // write controls
  input wire logic GLOBAL_WRITE_N,
  input wire logic BYTE_WRITE_GATE_N,
  input wire logic [`PSC_LANES-1:0] BYTE_LANE_SEL_N,
  // asynchronous pins and strap
  input wire logic SLEEP_REQUEST,
  input wire logic OUT_EN_N,
  input wire logic BURST_ORDER_SEL,
  // data pins, lane parity in bit 8 of each lane
  input wire logic [`PSC_DATA_W-1:0] DQ_IN,
  output logic [`PSC_DATA_W-1:0] DQ_OUT,
  output logic DQ_OE,
  // memory array side
  output logic [`PSC_ADDR_W-1:0] ARRAY_ADDR,
  output logic [`PSC_LANES-1:0] ARRAY_WE,
  output logic [`PSC_DATA_W-1:0] ARRAY_WDATA,
  input wire logic [`PSC_DATA_W-1:0] ARRAY_RDATA,
  // state
  output logic SLEEP_ACTIVE
);

  // synchronisers for sleep and the order strap
  logic sleep_m;
  logic sleep_s;
  logic order_m;
  logic order_s;

  // burst bookkeeping
  logic [`PSC_ADDR_W-1:0] base_addr;
  logic [`PSC_CNT_W-1:0] cnt;
  logic active;
  logic read_pend;
  logic drive;
  psc_pkg::psc_state_t state;
  psc_pkg::psc_state_t next_state;

  // every check below runs on the rising clock and rests during reset
  default clocking cb_chk @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);

  // two flops on sleep, which enters in two clocks anyway
  always_ff @(posedge CLOCK) begin
    sleep_m <= SLEEP_REQUEST;
    sleep_s <= sleep_m;
    order_m <= BURST_ORDER_SEL;
    order_s <= order_m;
  end

  // enable decode
  wire ce_ok = ~CHIP_SEL_PRIMARY_N & CHIP_SEL_SECOND & ~CHIP_SEL_THIRD_N;
  wire ce_bad = ~CHIP_SEL_SECOND | CHIP_SEL_THIRD_N;
  // processor strobe is dead while the primary enable is high
  wire p_take = ~PROC_ADDR_STROBE_N & ~CHIP_SEL_PRIMARY_N;
  wire c_take = ~CTRL_ADDR_STROBE_N;

  // combined write indication, low means write
  wire any_lane = ~&BYTE_LANE_SEL_N;
  wire write_n = ~(~GLOBAL_WRITE_N
    | (~BYTE_WRITE_GATE_N & any_lane)); // see (R10)

  // cycle classification
  wire deselect = ~sleep_s & ((CHIP_SEL_PRIMARY_N & c_take)
    | ((p_take | c_take) & ~CHIP_SEL_PRIMARY_N
    & ce_bad)); // see (R3)
  wire begin_p = ~sleep_s & p_take & ce_ok; // see (R5)
  wire begin_c = ~sleep_s & ~p_take & c_take & ce_ok; // see (R7)
  wire cont = ~sleep_s & ~p_take & ~c_take & active; // see (R20)
  wire step = cont & ~BURST_STEP_N; // see (R8)
  // a processor strobe cycle is a read, writes come later
  wire wr_cycle = (begin_c | cont) & ~write_n; // see (R6) (R17)
  wire rd_cycle = begin_p | ((begin_c | cont) & write_n);

  // next counter value and burst address bits
  // the order is applied on the way out, so one counter serves both
  // orders, and a strap change applies from the next address of a burst in progress
  wire [`PSC_CNT_W-1:0] cnt_nx =
    begin_p | begin_c ? `PSC_CNT_ZERO
    : step ? cnt + `PSC_CNT_ONE : cnt; // see (R9) (R16)
  wire [`PSC_CNT_W-1:0] start_lo = begin_p | begin_c
    ? ADDR[`PSC_CNT_W-1:0] : base_addr[`PSC_CNT_W-1:0];
  wire [`PSC_CNT_W-1:0] il_lo = start_lo ^ cnt_nx; // see (R1)
  wire [`PSC_CNT_W-1:0] ln_lo = start_lo + cnt_nx; // see (R2)
  wire [`PSC_CNT_W-1:0] lo_nx =
    order_s == `PSC_ORDER_INTERLEAVE ? il_lo : ln_lo;
  wire [`PSC_ADDR_W-1:0] hi_src = begin_p | begin_c ? ADDR : base_addr;
  wire [`PSC_ADDR_W-1:0] addr_nx =
    {hi_src[`PSC_ADDR_W-1:`PSC_CNT_W], lo_nx};

  // per-lane write enables, global write overrides the lanes
  logic [`PSC_LANES-1:0] lane_we;
  genvar g;
  generate
    for (g = 0; g < `PSC_LANES; g = g + 1) begin : g_lane
      assign lane_we[g] = wr_cycle & (~GLOBAL_WRITE_N
        | (~BYTE_WRITE_GATE_N & ~BYTE_LANE_SEL_N[g])); // see (R12)
    end
  endgenerate

  // next state of the access logic
  always_comb begin
    case (state)
      psc_pkg::PSC_ST_IDLE,
      psc_pkg::PSC_ST_READ,
      psc_pkg::PSC_ST_WRITE,
      psc_pkg::PSC_ST_SLEEP: begin
        if (sleep_s) begin
          next_state = psc_pkg::PSC_ST_SLEEP; // see (R4)
        end else if (wr_cycle) begin
          next_state = psc_pkg::PSC_ST_WRITE;
        end else if (rd_cycle) begin
          next_state = psc_pkg::PSC_ST_READ;
        end else begin
          next_state = psc_pkg::PSC_ST_IDLE;
        end
      end
      default: begin
        next_state = psc_pkg::PSC_ST_IDLE;
      end
    endcase
  end

  // state and burst registers
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      state <= psc_pkg::PSC_ST_IDLE;
      active <= 1'b0;
      cnt <= `PSC_CNT_ZERO;
      base_addr <= '0;
    end else begin
      state <= next_state;
      if (begin_p | begin_c) begin
        base_addr <= ADDR; // see (R16)
        active <= 1'b1;
      end else if (deselect | sleep_s) begin
        active <= 1'b0; // see (R3) (R4)
      end
      cnt <= cnt_nx;
    end
  end

  // array port, write data taken at the same rise
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      ARRAY_ADDR <= '0;
      ARRAY_WE <= `PSC_LANES_NONE;
      ARRAY_WDATA <= '0;
    end else begin
      if (rd_cycle | wr_cycle) begin
        ARRAY_ADDR <= addr_nx;
      end
      ARRAY_WE <= lane_we;
      ARRAY_WDATA <= DQ_IN;
    end
  end

  // output register: one stage of read latency
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      read_pend <= 1'b0;
      drive <= 1'b0;
      DQ_OUT <= '0;
      SLEEP_ACTIVE <= 1'b0;
    end else begin
      read_pend <= rd_cycle;
      // only a completed read drives; a fresh access is still empty
      drive <= read_pend & ~sleep_s & ~wr_cycle
        & ~deselect; // see (R18) (R19) (R13)
      if (read_pend) begin
        DQ_OUT <= ARRAY_RDATA; // see (R18)
      end
      SLEEP_ACTIVE <= sleep_s;
    end
  end

  // output enable is never sampled; writes mask it through drive
  assign DQ_OE = drive & ~OUT_EN_N; // see (R13) (R14) (R15)

  // checks: sleep and deselect keep the pins and the array quiet
  a_sleep_float: assert property ( // see (R4)
    sleep_s |=> !drive && ARRAY_WE == `PSC_LANES_NONE)
    else $error("pins or array active in sleep");
  a_sleep_state: assert property ( // see (R4)
    sleep_s |=> state == psc_pkg::PSC_ST_SLEEP && SLEEP_ACTIVE)
    else $error("sleep not entered");
  a_desel_float: assert property ( // see (R3) (R19)
    deselect |=> !drive ##1 !drive)
    else $error("pins driven after deselect");
  a_desel_primary: assert property ( // see (R3)
    c_take && CHIP_SEL_PRIMARY_N && !sleep_s
    |=> !drive && ARRAY_WE == `PSC_LANES_NONE)
    else $error("primary enable deselect not honoured");
  a_desel_end: assert property ( // see (R3)
    deselect |=> !active)
    else $error("burst survived a deselect");

  // checks: starting a burst
  a_proc_read: assert property ( // see (R5)
    begin_p |=> ARRAY_WE == `PSC_LANES_NONE
    && ARRAY_ADDR == $past(ADDR))
    else $error("processor strobe cycle did not read");
  a_read_state: assert property ( // see (R5)
    rd_cycle |=> state == psc_pkg::PSC_ST_READ)
    else $error("read cycle not recorded");
  a_proc_ignored: assert property ( // see (R5)
    !PROC_ADDR_STROBE_N && CHIP_SEL_PRIMARY_N && !c_take
    && !active && !sleep_s
    |=> ARRAY_WE == `PSC_LANES_NONE && $stable(ARRAY_ADDR))
    else $error("processor strobe taken with primary enable high");
  a_ctrl_write: assert property ( // see (R7)
    begin_c && !GLOBAL_WRITE_N |=> ARRAY_WE == `PSC_LANES_ALL)
    else $error("global write missed lanes");
  a_ctrl_addr: assert property ( // see (R7)
    begin_c |=> ARRAY_ADDR == $past(ADDR))
    else $error("controller strobe address not used");
  a_cnt_load: assert property ( // see (R16)
    begin_p || begin_c |=> cnt == `PSC_CNT_ZERO)
    else $error("counter not loaded at burst start");

  // checks: writes
  a_wr_gate: assert property ( // see (R6)
    ARRAY_WE != `PSC_LANES_NONE |-> $past(begin_c || cont))
    else $error("write without a legal cycle");
  a_write_state: assert property ( // see (R6)
    wr_cycle |=> state == psc_pkg::PSC_ST_WRITE)
    else $error("write cycle not recorded");
  a_lane_pick: assert property ( // see (R12)
    begin_c && GLOBAL_WRITE_N && !BYTE_WRITE_GATE_N
    |=> ARRAY_WE == ~$past(BYTE_LANE_SEL_N))
    else $error("lane enables wrong");
  a_wdata_take: assert property ( // see (R12)
    wr_cycle |=> ARRAY_WDATA == $past(DQ_IN))
    else $error("write data not taken");
  a_cont_global: assert property ( // see (R17)
    cont && !GLOBAL_WRITE_N |=> ARRAY_WE == `PSC_LANES_ALL)
    else $error("second cycle write missed lanes");
  a_oe_mask: assert property ( // see (R13)
    wr_cycle |=> !DQ_OE)
    else $error("pins driven in a write");

  // checks: burst stepping
  a_step_order: assert property ( // see (R2)
    step && !$past(sleep_s) && order_s == `PSC_ORDER_LINEAR
    |=> ARRAY_ADDR[`PSC_CNT_W-1:0]
    == $past(ARRAY_ADDR[`PSC_CNT_W-1:0]) + `PSC_CNT_ONE)
    else $error("linear step wrong");
  a_step_il: assert property ( // see (R1)
    begin_p ##1 step && order_s == `PSC_ORDER_INTERLEAVE
    |=> ARRAY_ADDR[`PSC_CNT_W-1:0]
    == ($past(ARRAY_ADDR[`PSC_CNT_W-1:0]) ^ `PSC_CNT_ONE))
    else $error("interleave step wrong");
  a_hold_addr: assert property ( // see (R9)
    cont && BURST_STEP_N |=> $stable(ARRAY_ADDR))
    else $error("suspend moved the address");
  a_hold_cnt: assert property ( // see (R9)
    cont && BURST_STEP_N |=> $stable(cnt))
    else $error("suspend moved the counter");

  // checks: read path
  a_read_lat: assert property ( // see (R18)
    rd_cycle ##1 !sleep_s && !wr_cycle && !deselect
    |=> drive && DQ_OUT == $past(ARRAY_RDATA))
    else $error("read data not out after one clock");
  a_read_idle: assert property ( // see (R14) (R19)
    !read_pend |=> !drive)
    else $error("pins driven without a read");
  a_idle_state: assert property ( // see (R20)
    !rd_cycle && !wr_cycle && !sleep_s |=> state == psc_pkg::PSC_ST_IDLE)
    else $error("idle cycle not recorded");

endmodule : psc_core
`default_nettype wire

// ---- testbench/psc_mem_model.sv ----
// behavioural array memory on the far side of the cycle control
`default_nettype none
module psc_mem_model (
  // clock
  input wire logic clock,
  // array side
  input wire logic [19:0] addr,
  input wire logic [3:0] we,
  input wire logic [35:0] wdata,
  output logic [35:0] rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [35:0] mem [16];
  // only four address bits kept, enough for the bursts tried
  assign rdata = mem[addr[3:0]];
  // array starts cleared so reads of unwritten words are known
  initial begin
    for (int i = 0; i < 16; i++) begin
      mem[i] = 36'h0;
    end
  end
  // per-lane store, lanes not enabled keep their value
  always @(posedge clock) begin
    for (int i = 0; i < 4; i++) begin
      if (we[i]) mem[addr[3:0]][9*i +: 9] <= wdata[9*i +: 9];
    end
  end
endmodule : psc_mem_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
// self-checking bench of the sram cycle control
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n = 0, ps_n = 1, cs_n = 1, step_n = 1, ce1_n = 0;
  logic ce2 = 1, ce3_n = 0, gw_n = 1, bwe_n = 1, slp = 0, oe_n = 0;
  logic mode = 1, oe, sact;
  logic [3:0] bsel_n = 4'hF, awe;
  logic [19:0] addr = 20'h0, aaddr;
  logic [35:0] din = 36'h0, dout, wd, rd;
  int mismatches = 0, checked = 0, cycles = 0;
  psc_core i_dut (.CLOCK(clk), .RST_N(rst_n), .ADDR(addr),
    .PROC_ADDR_STROBE_N(ps_n), .CTRL_ADDR_STROBE_N(cs_n),
    .BURST_STEP_N(step_n), .CHIP_SEL_PRIMARY_N(ce1_n),
    .CHIP_SEL_SECOND(ce2), .CHIP_SEL_THIRD_N(ce3_n),
    .GLOBAL_WRITE_N(gw_n), .BYTE_WRITE_GATE_N(bwe_n),
    .BYTE_LANE_SEL_N(bsel_n), .SLEEP_REQUEST(slp), .OUT_EN_N(oe_n),
    .BURST_ORDER_SEL(mode), .DQ_IN(din), .DQ_OUT(dout), .DQ_OE(oe),
    .ARRAY_ADDR(aaddr), .ARRAY_WE(awe), .ARRAY_WDATA(wd),
    .ARRAY_RDATA(rd), .SLEEP_ACTIVE(sact));
  psc_mem_model i_mem (.clock(clk), .addr(aaddr), .we(awe),
    .wdata(wd), .rdata(rd));
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test
  // one strobe cycle, called at a rising edge; k high is processor
  task automatic start(input logic k, input logic [19:0] a);
    ps_n <= !k;
    cs_n <= k;
    addr <= a;
    @(posedge clk);
    ps_n <= 1'b1;
    cs_n <= 1'b1;
    gw_n <= 1'b1;
    bwe_n <= 1'b1;
    bsel_n <= 4'hF;
    @(negedge clk);
  endtask : start
  // global write low on purpose, the strobe must still read
  task automatic t_read(input logic [19:0] a, input logic [35:0] e);
    @(posedge clk);
    gw_n <= 1'b0;
    oe_n <= 1'b0;
    start(1'b1, a);
    chk(awe, 4'h0);
    chk(aaddr, a);
    @(negedge clk);
    chk(dout, e);
    chk(oe, 1'b1);
    $display("read done");
  endtask : t_read
  task automatic t_writes;
    @(posedge clk);
    oe_n <= 1'b1;
    gw_n <= 1'b0;
    din <= 36'h123456789;
    start(1'b0, 20'h00004);
    chk(awe, 4'hF);
    t_read(20'h00004, 36'h123456789);
    @(posedge clk);
    oe_n <= 1'b1;
    bwe_n <= 1'b0;
    bsel_n <= 4'hA;
    din <= 36'hFFFFFFFFF;
    start(1'b0, 20'h00004);
    chk(awe, 4'h5);
    t_read(20'h00004, 36'h123456789 | 36'h007FC01FF);
    // processor strobe cycle first, the write lands on the next rise
    @(posedge clk);
    oe_n <= 1'b1;
    gw_n <= 1'b0;
    ps_n <= 1'b0;
    addr <= 20'h00005;
    @(posedge clk);
    ps_n <= 1'b1;
    oe_n <= 1'b0;
    din <= 36'h0A5A5A5A5;
    @(negedge clk);
    chk(awe, 4'h0);
    @(posedge clk);
    gw_n <= 1'b1;
    @(negedge clk);
    chk(awe, 4'hF);
    chk(wd, 36'h0A5A5A5A5);
    chk(oe, 1'b0);
    repeat (2) @(posedge clk);
    oe_n <= 1'b1;
    @(negedge clk);
    chk(dout, 36'h0A5A5A5A5);
    chk(oe, 1'b0);
    @(posedge clk);
    oe_n <= 1'b0;
    @(negedge clk);
    chk(oe, 1'b1);
    $display("writes done");
  endtask : t_writes
  // strap md, start s, three stepped low bits packed first to last
  task automatic t_burst(input logic md, input logic [1:0] s,
      input logic [5:0] e);
    @(posedge clk);
    mode <= md;
    repeat (3) @(posedge clk);
    step_n <= 1'b0;
    start(1'b1, {18'h0, s});
    for (int i = 2; i >= 0; i--) begin
      @(negedge clk);
      chk(aaddr[1:0], e[2*i +: 2]);
    end
    @(posedge clk);
    step_n <= 1'b1;
    @(negedge clk);
    chk(aaddr[1:0], s);
    $display("burst done");
  endtask : t_burst
  task automatic t_off;
    @(posedge clk);
    ce2 <= 1'b0;
    start(1'b0, 20'h00008);
    chk(oe, 1'b0);
    chk(aaddr, 20'h00003);
    @(posedge clk);
    ce2 <= 1'b1;
    ce1_n <= 1'b1;
    start(1'b1, 20'h00008);
    chk(aaddr, 20'h00003);
    @(posedge clk);
    ce1_n <= 1'b0;
    slp <= 1'b1;
    repeat (3) @(posedge clk);
    gw_n <= 1'b0;
    start(1'b0, 20'h0000C);
    chk(sact, 1'b1);
    chk(awe, 4'h0);
    chk(oe, 1'b0);
    @(posedge clk);
    slp <= 1'b0;
    $display("deselect and sleep done");
  endtask : t_off
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard, the whole run needs well under 200 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      mismatches++;
      finish_test();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_writes();
    t_burst(1'b1, 2'b01, 6'b001110);
    t_burst(1'b0, 2'b11, 6'b000110);
    t_off();
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
